// ===== hw/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
// register addresses on the plain register port
`define TCC_ADDR_W 3
`define TCC_ADDR_CTRL1 3'h0
`define TCC_ADDR_CTRL2 3'h1
`define TCC_ADDR_CTRL3 3'h2
`define TCC_ADDR_STAT 3'h3
`define TCC_ADDR_REF 3'h4
// comparator control fields
`define TCC_B_ON 15
`define TCC_B_PIN 14
`define TCC_B_INV 13
`define TCC_B_EVT 9
`define TCC_B_RES 8
`define TCC_B_EDGE_HI 7
`define TCC_B_EDGE_LO 6
`define TCC_B_PLUS 4
`define TCC_B_MINUS_HI 1
`define TCC_B_MINUS_LO 0
// shared status fields
`define TCC_B_IDLE 15
`define TCC_B_EVCOPY 8
`define TCC_B_RESCOPY 0
// reference control fields
`define TCC_B_EXTREF 10
`define TCC_B_SRC_HI 9
`define TCC_B_SRC_LO 8
`define TCC_B_PWR 7
`define TCC_B_ROE 6
`define TCC_B_SUPPLY 5
`define TCC_B_LVL_HI 4
// writable bit masks, unimplemented bits read zero
`define TCC_CTRL_WMASK 16'hE2D3
`define TCC_REF_WMASK 16'h07FF
// reset values
`define TCC_CTRL_RST 16'h0000
`define TCC_REF_RST 16'h0000
// edge select codes
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_ANY 2'h3
`endif

// ===== hw/tcc_pkg.sv
package tcc_pkg;
  typedef struct packed {
    logic [2:0] on;
    logic [2:0] pin;
    logic [2:0] inv;
    logic [2:0] evt;
    logic [5:0] edge_sel;
    logic [2:0] plus_sel;
    logic [5:0] minus_sel;
    logic idle_stop;
    logic [10:0] ref_ctl;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    logic [2:0] pin_oe;
    logic [2:0] pin_val;
    logic [15:0] rdata;
    logic [2:0] run;
  } tcc_state_s;
endpackage

// ===== hw/tcc_top.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
// Summary of operation
// - comparator runs only while its enable set
// - pin drive enable routes result to pin
// - pin path bypasses every synchroniser
// - invert bit flips the reported result
// - event sets sticky flag, blocks further events
// - code 11 fires on any change
// - code 10 fires falling, rising if inverted
// - code 01 fires rising, falling if inverted
// - code 00 fires nothing
// - plus select picks reference or first pin
// - minus select picks pins or reference
// - unimplemented bits read back zero
// - idle stop halts all comparators in idle
// - status mirrors event flags at 10..8
// - status mirrors results at 2..0
// - external ref select matters under plus select
// - source field matters under minus code 11
// - ladder power bit powers the ladder
// - ladder pin output connects level to pin
// - supply select picks external or analog rails
// - level code sets low plus code/32 span
module tcc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [`TCC_ADDR_W-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic idle_mode_i,
  input wire logic [2:0] analog_result_i,
  output logic [2:0] comparator_on_o,
  output logic [2:0] plus_input_select_o,
  output logic [5:0] minus_input_select_o,
  output logic [2:0] comparator_output_pin_o,
  output logic [2:0] comparator_output_pin_oe_o,
  output logic [2:0] event_pulse_o,
  output logic external_ref_select_o,
  output logic [1:0] reference_source_field_o,
  output logic ladder_power_o,
  output logic ladder_pin_output_o,
  output logic ladder_supply_select_o,
  output logic [4:0] ladder_level_code_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // event condition for one comparator from its edge select and polarity
  function automatic logic edge_hit(input logic [1:0] sel, input logic inv,
                                    input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (sel)
      `TCC_EDGE_ANY: edge_hit = rise | fall;
      `TCC_EDGE_FALL: edge_hit = inv ? rise : fall;
      `TCC_EDGE_RISE: edge_hit = inv ? fall : rise;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // assemble a comparator control word, unused bits zero
  function automatic logic [15:0] ctrl_word(input tcc_pkg::tcc_state_s s, input int i);
    logic [15:0] w;
    w = 16'h0000;
    w[`TCC_B_ON] = s.on[i];
    w[`TCC_B_PIN] = s.pin[i];
    w[`TCC_B_INV] = s.inv[i];
    w[`TCC_B_EVT] = s.evt[i];
    w[`TCC_B_RES] = s.prev[i];
    w[`TCC_B_EDGE_HI:`TCC_B_EDGE_LO] = s.edge_sel[2*i +: 2];
    w[`TCC_B_PLUS] = s.plus_sel[i];
    w[`TCC_B_MINUS_HI:`TCC_B_MINUS_LO] = s.minus_sel[2*i +: 2];
    ctrl_word = w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  tcc_pkg::tcc_state_s st_ff;
  tcc_pkg::tcc_state_s nxt_st;
  logic [2:0] raw_cmp;

  // raw analog result, passed through ungated; the run bit gates it downstream
  assign raw_cmp = analog_result_i;

  // next state: register writes, synchronisers, edge detection
  always_comb begin
    nxt_st = st_ff;
    // two flops on the asynchronous result, polarity applied after
    nxt_st.sync1 = raw_cmp;
    nxt_st.sync2 = st_ff.sync1;
    for (int i = 0; i < 3; i++) begin
      logic cur;
      cur = st_ff.run[i] & (st_ff.sync2[i] ^ st_ff.inv[i]);
      nxt_st.prev[i] = cur;
      // set wins over a software clear in the same cycle
      if (wr_i && addr_i == 3'(i) && !wdata_i[`TCC_B_EVT]) begin
        nxt_st.evt[i] = 1'b0;
      end
      if (!st_ff.evt[i] && st_ff.run[i] &&
          edge_hit(st_ff.edge_sel[2*i +: 2], st_ff.inv[i], st_ff.prev[i], cur)) begin
        nxt_st.evt[i] = 1'b1;
      end
    end
    // register writes; event flag only cleared, never set, by software
    if (wr_i) begin
      for (int i = 0; i < 3; i++) begin
        if (addr_i == 3'(i)) begin
          nxt_st.on[i] = wdata_i[`TCC_B_ON];
          nxt_st.pin[i] = wdata_i[`TCC_B_PIN];
          nxt_st.inv[i] = wdata_i[`TCC_B_INV];
          nxt_st.edge_sel[2*i +: 2] = wdata_i[`TCC_B_EDGE_HI:`TCC_B_EDGE_LO];
          nxt_st.plus_sel[i] = wdata_i[`TCC_B_PLUS];
          nxt_st.minus_sel[2*i +: 2] = wdata_i[`TCC_B_MINUS_HI:`TCC_B_MINUS_LO];
        end
      end
      if (addr_i == `TCC_ADDR_STAT) begin
        nxt_st.idle_stop = wdata_i[`TCC_B_IDLE]; // copies ignore writes
      end
      if (addr_i == `TCC_ADDR_REF) begin
        nxt_st.ref_ctl = wdata_i[10:0] & 11'(`TCC_REF_WMASK);
      end
    end
    // run and pin state follow the new settings, so a write shows next cycle
    for (int i = 0; i < 3; i++) begin
      nxt_st.run[i] = nxt_st.on[i] & ~(nxt_st.idle_stop & idle_mode_i);
      // pin value registered once from the raw result, inverted and gated by run; the pad sees that flop
      nxt_st.pin_oe[i] = nxt_st.pin[i] & nxt_st.run[i];
      nxt_st.pin_val[i] = nxt_st.run[i] & (raw_cmp[i] ^ nxt_st.inv[i]);
    end
    // read data valid only in the cycle after the strobe
    nxt_st.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `TCC_ADDR_CTRL1: nxt_st.rdata = ctrl_word(st_ff, 0) & `TCC_CTRL_WMASK | 16'h0300 &
                                        ctrl_word(st_ff, 0);
        `TCC_ADDR_CTRL2: nxt_st.rdata = ctrl_word(st_ff, 1);
        `TCC_ADDR_CTRL3: nxt_st.rdata = ctrl_word(st_ff, 2);
        `TCC_ADDR_STAT: begin
          nxt_st.rdata[`TCC_B_IDLE] = st_ff.idle_stop;
          nxt_st.rdata[`TCC_B_EVCOPY +: 3] = st_ff.evt;
          nxt_st.rdata[`TCC_B_RESCOPY +: 3] = st_ff.prev;
        end
        `TCC_ADDR_REF: nxt_st.rdata = {5'h00, st_ff.ref_ctl};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from the state register, except the event pulse from its own flop

  // event pulse lasts one cycle on the flag's rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_pulse_o <= 3'h0;
    end else if (ce_i) begin
      event_pulse_o <= nxt_st.evt & ~st_ff.evt;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign comparator_on_o = st_ff.run;
  assign plus_input_select_o = st_ff.plus_sel;
  assign minus_input_select_o = st_ff.minus_sel;
  assign comparator_output_pin_o = st_ff.pin_val;
  assign comparator_output_pin_oe_o = st_ff.pin_oe;
  assign external_ref_select_o = st_ff.ref_ctl[`TCC_B_EXTREF];
  assign reference_source_field_o = st_ff.ref_ctl[`TCC_B_SRC_HI:`TCC_B_SRC_LO];
  assign ladder_power_o = st_ff.ref_ctl[`TCC_B_PWR];
  assign ladder_pin_output_o = st_ff.ref_ctl[`TCC_B_ROE];
  assign ladder_supply_select_o = st_ff.ref_ctl[`TCC_B_SUPPLY];
  assign ladder_level_code_o = st_ff.ref_ctl[`TCC_B_LVL_HI:0];

endmodule // tcc_top

// ===== verification/tcc_analog_model.sv
`timescale 1ns/1ps
// far side: three raw comparator decisions, landing off the clock grid
module tcc_analog_model (
  input wire logic [2:0] level_i,
  input wire logic slow_i,
  output logic [2:0] analog_result_o
);
  // slow stands for a lazily settling input, several cycles late
  initial analog_result_o = 3'h0;
  always @(level_i) begin
    #(slow_i ? 33 : 3);
    analog_result_o = level_i;
  end
endmodule // tcc_analog_model

// ===== verification/tcc_top_props.sv
`timescale 1ns/1ps
module tcc_top_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic idle_mode_i,
  input wire logic [2:0] analog_result_i,
  input wire logic [2:0] comparator_on_o,
  input wire logic [2:0] comparator_output_pin_o,
  input wire logic [2:0] comparator_output_pin_oe_o,
  input wire logic [2:0] event_pulse_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // idle-stop written, then three idle cycles with no write
  sequence s_idle_armed;
    wr_i && addr_i == 3'h3 && wdata_i[15] ##1 !wr_i ##1 (idle_mode_i && !wr_i) [*3];
  endsequence
  sequence s_ctrl_wr_rd;
    wr_i && addr_i == 3'h0 ##1 !wr_i ##1 rd_i && addr_i == 3'h0;
  endsequence
  ////////////////////////////////////////
  chk_read_gap_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero between reads");
  chk_unused_bits: assert property ($past(rd_i) |-> (rdata_o & ($past(addr_i) < 3'h3 ?
    16'h1C2C : $past(addr_i) == 3'h3 ? 16'h78F8 : 16'hF800)) == 16'h0000)
    else $error("unimplemented bit read as one");
  chk_enable_write: assert property (wr_i && addr_i == 3'h0 && !idle_mode_i |=>
    comparator_on_o[0] == |($past(wdata_i) & 16'h8000))
    else $error("enable write not reflected");
  chk_ctrl_readback: assert property (s_ctrl_wr_rd |=>
    ((rdata_o ^ $past(wdata_i, 3)) & 16'hE0D3) == 16'h0000)
    else $error("control read back differs");
  chk_pulse_single: assert property (|event_pulse_o |=>
    (event_pulse_o & $past(event_pulse_o)) == 3'h0)
    else $error("event pulse longer than one cycle");
  chk_pin_gated: assert property ((comparator_output_pin_oe_o & ~comparator_on_o) == 3'h0)
    else $error("pin driven while comparator stopped");
  chk_pin_unsynced: assert property (comparator_output_pin_oe_o[1] &&
    $changed(analog_result_i[1]) && !wr_i && !$past(wr_i) |=>
    !comparator_output_pin_oe_o[1] || $changed(comparator_output_pin_o[1]))
    else $error("pin lags raw result");
  chk_idle_halt: assert property (s_idle_armed |-> comparator_on_o == 3'h0)
    else $error("comparator runs in idle");
endmodule // tcc_top_props
bind tcc_top tcc_top_props u_props (.*);

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, ce_i, wr_i, rd_i, idle_mode_i, slow, rd_seen;
  logic [2:0] addr_i, lvl, analog_result_i, comparator_on_o, plus_input_select_o;
  logic [2:0] comparator_output_pin_o, comparator_output_pin_oe_o, event_pulse_o;
  logic [5:0] minus_input_select_o;
  logic [15:0] wdata_i, rdata_o, d, exp_q[$];
  logic external_ref_select_o, ladder_power_o, ladder_pin_output_o, ladder_supply_select_o;
  logic [1:0] reference_source_field_o;
  logic [4:0] ladder_level_code_o;
  logic [10:0] ref_w;
  logic [31:0] seed = 32'hB53453F4;
  int n_errors = 0;
  int n_compared = 0;
  int n_ev = 0;
  assign ref_w = {external_ref_select_o, reference_source_field_o, ladder_power_o,
    ladder_pin_output_o, ladder_supply_select_o, ladder_level_code_o};
  tcc_top DUT (.*);
  tcc_analog_model u_far (.level_i(lvl), .slow_i(slow), .analog_result_o(analog_result_i));
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [15:0] s, logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one strobe cycle; a read notes its expected data for the watcher
  task automatic bus(logic w, logic [2:0] a, logic [15:0] v);
    @(posedge clk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= v;
    if (!w) exp_q.push_back(v);
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(negedge clk_i);
  endtask
  // sync flops plus edge register need a few cycles; eight is ample
  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask
  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // read data are due the cycle after the strobe; comparator 0 pulses are counted here
  always @(negedge clk_i) begin
    if (rd_seen) chk(rdata_o, exp_q.pop_front());
    rd_seen = rd_i;
    n_ev += int'(event_pulse_o[0]);
  end
  initial begin
    {rst_i, ce_i, wr_i, rd_i, idle_mode_i, slow, rd_seen, lvl, addr_i, wdata_i} = {2'h3, 27'h0};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) bus(0, 3'(a), 16'h0000);
    // random ladder settings reach the pins and read back masked
    repeat (4) begin
      d = 16'(rnd());
      bus(1, 3'h4, d);
      chk(16'(ref_w), d & 16'h07FF);
      bus(0, 3'h4, d & 16'h07FF);
    end
    for (int c = 0; c < 3; c++) bus(1, 3'(c), 16'hFF3F);
    settle();
    chk(16'({comparator_on_o, comparator_output_pin_oe_o}), 16'h003F);
    chk(16'({plus_input_select_o, minus_input_select_o}), 16'h01FF);
    chk(16'(comparator_output_pin_o), 16'h0007);
    for (int c = 0; c < 3; c++) bus(0, 3'(c), 16'hE113);
    bus(1, 3'h3, 16'hFFFF);
    @(posedge clk_i);
    idle_mode_i <= 1'b1;
    settle();
    chk(16'(comparator_on_o), 16'h0000);
    @(posedge clk_i);
    idle_mode_i <= 1'b0;
    settle();
    bus(0, 3'h3, 16'h8007);
    bus(1, 3'h3, 16'h0000);
    // every edge code at both polarities: quick raw rise, then slow raw fall
    for (int v = 0; v < 8; v++) begin
      d = {2'h2, v[2], 5'h00, v[1:0], 6'h00};
      bus(1, 3'h0, d);
      settle();
      bus(1, 3'h0, d);
      n_ev = 0;
      slow = 1'b0;
      lvl = 3'h1;
      settle();
      chk(16'(n_ev), 16'(v[0]));
      slow = 1'b1;
      lvl = 3'h0;
      repeat (2) settle();
      chk(16'(n_ev), 16'(v[1:0] != 2'h0));
      bus(0, 3'h0, d | {6'h00, v[1:0] != 2'h0, v[2], 8'h00});
      bus(0, 3'h3, {7'h00, v[1:0] != 2'h0, 5'h00, 2'h3, v[2]});
    end
    bus(1, 3'h0, d);
    bus(0, 3'h0, d | 16'h0100);
    slow = 1'b0;
    @(posedge clk_i);
    lvl = 3'h2;
    repeat (2) @(negedge clk_i);
    chk(16'(comparator_output_pin_o[1]), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      bus(1, 3'h2, 16'hE000 | 16'(m));
      chk(16'({plus_input_select_o[2], minus_input_select_o[5:4]}), 16'(m));
    end
    finish_test();
  end
endmodule // testbench
